// file: mdc_defs.vh
// Register map, field positions, codes and reset values of the DMA controller
`ifndef MDC_DEFS_VH
`define MDC_DEFS_VH

`define MDC_OFF_CFG 8'h00
`define MDC_OFF_SRC 8'h04
`define MDC_OFF_SSTR 8'h08
`define MDC_OFF_XCNT 8'h0C
`define MDC_OFF_YCNT 8'h10
`define MDC_OFF_YMOD 8'h14
`define MDC_OFF_DST 8'h18
`define MDC_OFF_DSTR 8'h1C
`define MDC_OFF_DPTR 8'h20
`define MDC_OFF_CUR 8'h24
`define MDC_OFF_STAT 8'h28
`define MDC_OFF_ISTAT 8'h2C
`define MDC_OFF_IMASK 8'h30
`define MDC_OFF_CRC 8'h34
`define MDC_OFF_CRCX 8'h38
`define MDC_OFF_DCNT 8'h3C
`define MDC_OFF_XLEFT 8'h40

`define MDC_CFG_W 10
`define MDC_CFG_EN 0
`define MDC_CFG_FLOW_LO 1
`define MDC_CFG_FLOW_HI 3
`define MDC_CFG_DIR_LO 4
`define MDC_CFG_DIR_HI 5
`define MDC_CFG_CRC 6
`define MDC_CFG_CMP 7
`define MDC_CFG_FRAC_LO 8
`define MDC_CFG_FRAC_HI 9

`define MDC_FLOW_STOP 3'h0
`define MDC_FLOW_CIRC 3'h1
`define MDC_FLOW_PING 3'h2
`define MDC_FLOW_LIST 3'h3
`define MDC_FLOW_ARRAY 3'h4
`define MDC_FLOW_LIST2D 3'h5

`define MDC_DIR_MEM 2'h0
`define MDC_DIR_PACED 2'h1
`define MDC_DIR_SCRUB 2'h2

`define MDC_FRAC_HALF 2'h1
`define MDC_FRAC_QUART 2'h2

`define MDC_WORDS_PING 3'h2
`define MDC_WORDS_LIST 3'h4
`define MDC_WORDS_ARRAY 3'h1
`define MDC_WORDS_LIST2D 3'h7

`define MDC_SLOT_NEXT 3'h0
`define MDC_SLOT_ADDR 3'h1
`define MDC_SLOT_XCNT 3'h2
`define MDC_SLOT_CFG 3'h3
`define MDC_SLOT_STR 3'h4
`define MDC_SLOT_YCNT 3'h5
`define MDC_SLOT_YMOD 3'h6

`define MDC_IRQ_W 4
`define MDC_IRQ_DONE 0
`define MDC_IRQ_WRAP 1
`define MDC_IRQ_FRAC 2
`define MDC_IRQ_CRC 3

`define MDC_RST_CFG 10'h000
`define MDC_RST_CNT 16'h0001
`define MDC_RST_WORD 32'h00000000
`define MDC_CRC_POLY 32'h04C11DB7
`define MDC_CRC_INIT 32'hFFFFFFFF
`define MDC_WORD_BYTES 32'h00000004

`endif

// file: mdc_crc.v
// CRC-32 accumulator over 32-bit data words, MSB first
`timescale 1ns/10ps
`default_nettype none
`include "mdc_defs.vh"
module mdc_crc (
	input wire clk_i,
	input wire rst_i,
	input wire clr_i,
	input wire en_i,
	input wire [31:0] dat_i,
	output reg [31:0] crc_o
);
	reg [31:0] crc_nxt;
	integer i;

	always @* begin
		crc_nxt = crc_o;
		for (i = 31; i >= 0; i = i - 1) begin
			if (crc_nxt[31] ^ dat_i[i])
				crc_nxt = {crc_nxt[30:0], 1'b0} ^ `MDC_CRC_POLY;
			else
				crc_nxt = {crc_nxt[30:0], 1'b0};
		end
	end

	// Clear wins so a new block never inherits a stale sum
	always @(posedge clk_i) begin
		if (rst_i || clr_i)
			crc_o <= `MDC_CRC_INIT;
		else if (en_i)
			crc_o <= crc_nxt;
	end
endmodule // mdc_crc
`default_nettype wire

// file: mdc_dma.v
// Multimode single-channel DMA with Wishbone register slave and data master
`timescale 1ns/10ps
`default_nettype none
`include "mdc_defs.vh"
module mdc_dma #(
	parameter CW = 16
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output wire m_cyc_o,
	output wire m_stb_o,
	output wire m_we_o,
	output wire [31:0] m_adr_o,
	output wire [3:0] m_sel_o,
	output wire [31:0] m_dat_o,
	input wire [31:0] m_dat_i,
	input wire m_ack_i,
	input wire prq_i,
	output wire irq_o
);
	localparam S_IDLE = 3'h0;
	localparam S_FETCH = 3'h1;
	localparam S_LOAD = 3'h2;
	localparam S_RD = 3'h3;
	localparam S_WR = 3'h4;
	localparam S_STEP = 3'h5;
	localparam S_END = 3'h6;

	// Setup registers
	reg [`MDC_CFG_W-1:0] cfg_r;
	reg [31:0] src_r;
	reg [31:0] sstr_r;
	reg [CW-1:0] xcnt_r;
	reg [CW-1:0] ycnt_r;
	reg [31:0] ymod_r;
	reg [31:0] dst_r;
	reg [31:0] dstr_r;
	reg [31:0] dptr_r;
	reg [CW-1:0] dcnt_r;
	reg [`MDC_IRQ_W-1:0] imask_r;
	reg [`MDC_IRQ_W-1:0] istat_r;
	reg [31:0] crcx_r;
	// Working state
	reg [2:0] state_r;
	reg [31:0] csrc_r;
	reg [31:0] cdst_r;
	reg [31:0] wstr_r;
	reg [31:0] wymod_r;
	reg [CW-1:0] wxcnt_r;
	reg [CW-1:0] wycnt_r;
	reg [CW-1:0] xleft_r;
	reg [CW-1:0] yleft_r;
	reg [CW-1:0] aleft_r;
	reg [`MDC_CFG_W-1:0] wcfg_r;
	reg [31:0] link_r;
	reg [31:0] wptr_r;
	reg [2:0] fidx_r;
	reg [31:0] data_r;
	reg crc_clr_r;
	// Data master
	reg mcyc_r;
	reg mwe_r;
	reg [31:0] madr_r;
	reg [31:0] mdat_r;

	wire [31:0] crc_w;
	wire bus_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr_en = bus_hit & wb_we_i;
	wire [2:0] flow = wcfg_r[`MDC_CFG_FLOW_HI:`MDC_CFG_FLOW_LO];
	wire [1:0] wdir = wcfg_r[`MDC_CFG_DIR_HI:`MDC_CFG_DIR_LO];
	wire [1:0] frac = wcfg_r[`MDC_CFG_FRAC_HI:`MDC_CFG_FRAC_LO];
	wire [2:0] new_flow = wb_dat_i[`MDC_CFG_FLOW_HI:`MDC_CFG_FLOW_LO];
	wire start = wr_en && wb_adr_i == `MDC_OFF_CFG && wb_sel_i[0] &&
		wb_dat_i[`MDC_CFG_EN] && state_r == S_IDLE;
	wire abort = wr_en && wb_adr_i == `MDC_OFF_CFG && wb_sel_i[0] &&
		!wb_dat_i[`MDC_CFG_EN] && state_r != S_IDLE;
	wire acked = mcyc_r & m_ack_i;
	wire is_link = flow == `MDC_FLOW_PING || flow == `MDC_FLOW_LIST ||
		flow == `MDC_FLOW_LIST2D;
	wire [2:0] nwords = flow == `MDC_FLOW_PING ? `MDC_WORDS_PING :
		flow == `MDC_FLOW_LIST ? `MDC_WORDS_LIST :
		flow == `MDC_FLOW_ARRAY ? `MDC_WORDS_ARRAY : `MDC_WORDS_LIST2D;
	wire [2:0] slot = flow == `MDC_FLOW_ARRAY ? `MDC_SLOT_ADDR : fidx_r;
	wire [CW-1:0] xl_n = xleft_r - {{(CW-1){1'b0}}, 1'b1};
	wire [CW-1:0] half_w = {1'b0, wxcnt_r[CW-1:1]};
	wire [CW-1:0] quart_w = {2'b00, wxcnt_r[CW-1:2]};
	wire [CW-1:0] three_w = half_w + quart_w;
	wire frac_hit = xl_n != {CW{1'b0}} &&
		((frac == `MDC_FRAC_HALF && xl_n == half_w) ||
		(frac == `MDC_FRAC_QUART &&
		(xl_n == half_w || xl_n == quart_w || xl_n == three_w)));
	wire blk_end = state_r == S_END;
	wire chain_end = (flow == `MDC_FLOW_STOP) ||
		(is_link && link_r == `MDC_RST_WORD) ||
		(flow == `MDC_FLOW_ARRAY && aleft_r <= {{(CW-1){1'b0}}, 1'b1});
	wire crc_bad = wcfg_r[`MDC_CFG_CMP] && crc_w != crcx_r;
	wire [`MDC_IRQ_W-1:0] ev;
	wire [`MDC_IRQ_W-1:0] w1c;

	assign ev[`MDC_IRQ_DONE] = blk_end & chain_end;
	assign ev[`MDC_IRQ_WRAP] = blk_end & (flow != `MDC_FLOW_STOP);
	assign ev[`MDC_IRQ_FRAC] = (state_r == S_STEP) & frac_hit;
	assign ev[`MDC_IRQ_CRC] = blk_end & crc_bad;
	assign w1c = (wr_en && wb_adr_i == `MDC_OFF_ISTAT && wb_sel_i[0]) ?
		wb_dat_i[`MDC_IRQ_W-1:0] : {`MDC_IRQ_W{1'b0}};
	assign irq_o = |(istat_r & imask_r);
	assign m_cyc_o = mcyc_r;
	assign m_stb_o = mcyc_r;
	assign m_we_o = mwe_r;
	assign m_adr_o = madr_r;
	assign m_dat_o = mdat_r;
	assign m_sel_o = 4'hF;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] val;
		input [3:0] sel;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (sel[b])
					merge[b*8 +: 8] = val[b*8 +: 8];
		end
	endfunction

	// Byte-merged write words, narrowed where the register is
	wire [31:0] cfg_m = merge({{(32-`MDC_CFG_W){1'b0}}, cfg_r}, wb_dat_i, wb_sel_i);
	wire [31:0] xcnt_m = merge({{(32-CW){1'b0}}, xcnt_r}, wb_dat_i, wb_sel_i);
	wire [31:0] ycnt_m = merge({{(32-CW){1'b0}}, ycnt_r}, wb_dat_i, wb_sel_i);
	wire [31:0] dcnt_m = merge({{(32-CW){1'b0}}, dcnt_r}, wb_dat_i, wb_sel_i);

	mdc_crc u_crc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(crc_clr_r),
		.en_i(state_r == S_RD && acked && wcfg_r[`MDC_CFG_CRC]),
		.dat_i(m_dat_i),
		.crc_o(crc_w)
	);

	// Register slave: one wait state, unmapped reads give zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `MDC_RST_WORD;
		end else begin
			wb_ack_o <= bus_hit;
			case (wb_adr_i)
			`MDC_OFF_CFG: wb_dat_o <= {{(32-`MDC_CFG_W){1'b0}}, cfg_r};
			`MDC_OFF_SRC: wb_dat_o <= src_r;
			`MDC_OFF_SSTR: wb_dat_o <= sstr_r;
			`MDC_OFF_XCNT: wb_dat_o <= {{(32-CW){1'b0}}, xcnt_r};
			`MDC_OFF_YCNT: wb_dat_o <= {{(32-CW){1'b0}}, ycnt_r};
			`MDC_OFF_YMOD: wb_dat_o <= ymod_r;
			`MDC_OFF_DST: wb_dat_o <= dst_r;
			`MDC_OFF_DSTR: wb_dat_o <= dstr_r;
			`MDC_OFF_DPTR: wb_dat_o <= dptr_r;
			`MDC_OFF_CUR: wb_dat_o <= csrc_r;
			`MDC_OFF_STAT: wb_dat_o <= {28'h0000000, state_r, state_r != S_IDLE};
			`MDC_OFF_ISTAT: wb_dat_o <= {{(32-`MDC_IRQ_W){1'b0}}, istat_r};
			`MDC_OFF_IMASK: wb_dat_o <= {{(32-`MDC_IRQ_W){1'b0}}, imask_r};
			`MDC_OFF_CRC: wb_dat_o <= crc_w;
			`MDC_OFF_CRCX: wb_dat_o <= crcx_r;
			`MDC_OFF_DCNT: wb_dat_o <= {{(32-CW){1'b0}}, dcnt_r};
			`MDC_OFF_XLEFT: wb_dat_o <= {{(32-CW){1'b0}}, xleft_r};
			default: wb_dat_o <= `MDC_RST_WORD;
			endcase
		end
	end

	// Setup register writes; enable bit also dropped by the engine at stop
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r <= `MDC_RST_CFG;
			src_r <= `MDC_RST_WORD;
			sstr_r <= `MDC_RST_WORD;
			xcnt_r <= `MDC_RST_CNT;
			ycnt_r <= `MDC_RST_CNT;
			ymod_r <= `MDC_RST_WORD;
			dst_r <= `MDC_RST_WORD;
			dstr_r <= `MDC_RST_WORD;
			dptr_r <= `MDC_RST_WORD;
			dcnt_r <= `MDC_RST_CNT;
			imask_r <= {`MDC_IRQ_W{1'b0}};
			crcx_r <= `MDC_RST_WORD;
			istat_r <= {`MDC_IRQ_W{1'b0}};
		end else begin
			// Set beats clear so no event is lost
			istat_r <= (istat_r & ~w1c) | ev;
			if (blk_end && chain_end)
				cfg_r[`MDC_CFG_EN] <= 1'b0;
			if (wr_en) begin
				case (wb_adr_i)
				`MDC_OFF_CFG: cfg_r <= cfg_m[`MDC_CFG_W-1:0];
				`MDC_OFF_SRC: src_r <= merge(src_r, wb_dat_i, wb_sel_i);
				`MDC_OFF_SSTR: sstr_r <= merge(sstr_r, wb_dat_i, wb_sel_i);
				`MDC_OFF_XCNT: xcnt_r <= xcnt_m[CW-1:0];
				`MDC_OFF_YCNT: ycnt_r <= ycnt_m[CW-1:0];
				`MDC_OFF_YMOD: ymod_r <= merge(ymod_r, wb_dat_i, wb_sel_i);
				`MDC_OFF_DST: dst_r <= merge(dst_r, wb_dat_i, wb_sel_i);
				`MDC_OFF_DSTR: dstr_r <= merge(dstr_r, wb_dat_i, wb_sel_i);
				`MDC_OFF_DPTR: dptr_r <= merge(dptr_r, wb_dat_i, wb_sel_i);
				`MDC_OFF_IMASK: imask_r <= wb_sel_i[0] ?
					wb_dat_i[`MDC_IRQ_W-1:0] : imask_r;
				`MDC_OFF_CRCX: crcx_r <= merge(crcx_r, wb_dat_i, wb_sel_i);
				`MDC_OFF_DCNT: dcnt_r <= dcnt_m[CW-1:0];
				default: cfg_r <= cfg_r;
				endcase
			end
		end
	end

	// Transfer engine and data-side master
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= S_IDLE;
			csrc_r <= `MDC_RST_WORD;
			cdst_r <= `MDC_RST_WORD;
			wstr_r <= `MDC_RST_WORD;
			wymod_r <= `MDC_RST_WORD;
			wxcnt_r <= `MDC_RST_CNT;
			wycnt_r <= `MDC_RST_CNT;
			xleft_r <= `MDC_RST_CNT;
			yleft_r <= `MDC_RST_CNT;
			aleft_r <= `MDC_RST_CNT;
			wcfg_r <= `MDC_RST_CFG;
			link_r <= `MDC_RST_WORD;
			wptr_r <= `MDC_RST_WORD;
			fidx_r <= 3'h0;
			data_r <= `MDC_RST_WORD;
			crc_clr_r <= 1'b0;
			mcyc_r <= 1'b0;
			mwe_r <= 1'b0;
			madr_r <= `MDC_RST_WORD;
			mdat_r <= `MDC_RST_WORD;
		end else begin
			crc_clr_r <= 1'b0;
			if (acked)
				mcyc_r <= 1'b0;
			if (abort) begin
				state_r <= S_IDLE;
				mcyc_r <= 1'b0;
			end else begin
				case (state_r)
				S_IDLE: begin
					if (start) begin
						wcfg_r <= wb_dat_i[`MDC_CFG_W-1:0];
						csrc_r <= src_r;
						cdst_r <= dst_r;
						wstr_r <= sstr_r;
						wymod_r <= ymod_r;
						wxcnt_r <= xcnt_r;
						wycnt_r <= ycnt_r;
						xleft_r <= xcnt_r;
						yleft_r <= ycnt_r;
						wptr_r <= dptr_r;
						aleft_r <= dcnt_r;
						fidx_r <= 3'h0;
						crc_clr_r <= 1'b1;
						if (new_flow == `MDC_FLOW_STOP || new_flow == `MDC_FLOW_CIRC)
							state_r <= S_RD;
						else
							state_r <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (!mcyc_r) begin
						mcyc_r <= 1'b1;
						mwe_r <= 1'b0;
						madr_r <= wptr_r + {27'h0000000, fidx_r, 2'b00};
					end else if (m_ack_i) begin
						case (slot)
						`MDC_SLOT_NEXT: link_r <= m_dat_i;
						`MDC_SLOT_ADDR: csrc_r <= m_dat_i;
						`MDC_SLOT_XCNT: wxcnt_r <= m_dat_i[CW-1:0];
						`MDC_SLOT_CFG: wcfg_r <= {m_dat_i[`MDC_CFG_W-1:`MDC_CFG_DIR_LO],
							wcfg_r[`MDC_CFG_FLOW_HI:0]};
						`MDC_SLOT_STR: wstr_r <= m_dat_i;
						`MDC_SLOT_YCNT: wycnt_r <= m_dat_i[CW-1:0];
						`MDC_SLOT_YMOD: wymod_r <= m_dat_i;
						default: link_r <= link_r;
						endcase
						fidx_r <= fidx_r + 3'h1;
						if (fidx_r == nwords - 3'h1)
							state_r <= S_LOAD;
					end
				end
				S_LOAD: begin
					xleft_r <= wxcnt_r;
					yleft_r <= wycnt_r;
					crc_clr_r <= 1'b1;
					state_r <= S_RD;
				end
				S_RD: begin
					// Paced mode waits for the peripheral before each element
					if (!mcyc_r && (wdir != `MDC_DIR_PACED || prq_i)) begin
						mcyc_r <= 1'b1;
						mwe_r <= 1'b0;
						madr_r <= csrc_r;
					end else if (acked) begin
						data_r <= m_dat_i;
						state_r <= (wdir == `MDC_DIR_SCRUB) ? S_STEP : S_WR;
					end
				end
				S_WR: begin
					if (!mcyc_r) begin
						mcyc_r <= 1'b1;
						mwe_r <= 1'b1;
						madr_r <= cdst_r;
						mdat_r <= data_r;
					end else if (m_ack_i) begin
						state_r <= S_STEP;
					end
				end
				S_STEP: begin
					cdst_r <= cdst_r + dstr_r;
					if (xleft_r > {{(CW-1){1'b0}}, 1'b1}) begin
						xleft_r <= xl_n;
						csrc_r <= csrc_r + wstr_r;
						state_r <= S_RD;
					end else if (yleft_r > {{(CW-1){1'b0}}, 1'b1}) begin
						// Row end: modifier replaces stride for 2D walks
						yleft_r <= yleft_r - {{(CW-1){1'b0}}, 1'b1};
						xleft_r <= wxcnt_r;
						csrc_r <= csrc_r + wymod_r;
						state_r <= S_RD;
					end else begin
						state_r <= S_END;
					end
				end
				S_END: begin
					fidx_r <= 3'h0;
					if (flow == `MDC_FLOW_STOP || flow == `MDC_FLOW_CIRC) begin
						// Addresses reload from the untouched setup copy, counts from the working copy
						csrc_r <= src_r;
						cdst_r <= dst_r;
						xleft_r <= wxcnt_r;
						yleft_r <= wycnt_r;
						crc_clr_r <= 1'b1;
						state_r <= (flow == `MDC_FLOW_CIRC) ? S_RD : S_IDLE;
					end else if (chain_end) begin
						state_r <= S_IDLE;
					end else if (flow == `MDC_FLOW_ARRAY) begin
						aleft_r <= aleft_r - {{(CW-1){1'b0}}, 1'b1};
						wptr_r <= wptr_r + `MDC_WORD_BYTES;
						state_r <= S_FETCH;
					end else begin
						wptr_r <= link_r;
						state_r <= S_FETCH;
					end
				end
				default: state_r <= S_IDLE;
				endcase
			end
		end
	end
endmodule // mdc_dma
`default_nettype wire

// file: mdc_dma_props.sv
// Port checker for the DMA controller, attached by bind
`timescale 1ns/10ps
`default_nettype none
`include "mdc_defs.vh"
module mdc_dma_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_ack_o,
	input wire logic m_cyc_o,
	input wire logic m_stb_o,
	input wire logic m_we_o,
	input wire logic [31:0] m_adr_o,
	input wire logic [3:0] m_sel_o,
	input wire logic m_ack_i,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("register ack longer than one cycle");
	a_ack_next_edge: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("register ack late");
	a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("register ack without request");
	// A control write that clears enable aborts a pending data access
	a_data_req_hold: assert property (m_cyc_o && !m_ack_i && !(wb_cyc_i && wb_stb_i && !wb_ack_o
		&& wb_we_i && wb_adr_i == `MDC_OFF_CFG) |=> m_cyc_o && $stable(m_adr_o) && $stable(m_we_o))
		else $error("data request changed before ack");
	a_data_req_drop: assert property (m_cyc_o && m_ack_i |=> !m_cyc_o)
		else $error("data request not released after ack");
	a_data_stb_cyc: assert property (m_stb_o == m_cyc_o)
		else $error("data strobe differs from cycle");
	a_data_sel_full: assert property (m_cyc_o |-> m_sel_o == 4'hF)
		else $error("data byte enables not full word");
	a_reset_quiet: assert property ($fell(rst_i) |-> !m_cyc_o && !wb_ack_o && !irq_o)
		else $error("outputs active after reset");
endmodule // mdc_dma_props
bind mdc_dma mdc_dma_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_ack_o(wb_ack_o), .m_cyc_o(m_cyc_o), .m_stb_o(m_stb_o),
	.m_we_o(m_we_o), .m_adr_o(m_adr_o), .m_sel_o(m_sel_o), .m_ack_i(m_ack_i), .irq_o(irq_o));
`default_nettype wire

// file: mdc_fab.sv
// Memory model on the data side, prompt or slow Wishbone slave
`timescale 1ns/10ps
`default_nettype none
module mdc_fab (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o
);
	logic [31:0] mem [0:63];
	logic [1:0] wait_r;
	initial begin
		for (int j = 0; j < 64; j++) mem[j] = 32'hA0000000 + j;
		dat_o = 32'h0;
		ack_o = 1'b0;
		wait_r = 2'h0;
	end
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		if (rst_i) begin
			wait_r <= 2'h0;
		end else if (cyc_i && stb_i && !ack_o) begin
			if (wait_r == (slow_i ? 2'h3 : 2'h0)) begin
				ack_o <= 1'b1;
				wait_r <= 2'h0;
				if (we_i) mem[adr_i[7:2]] <= dat_i;
				else dat_o <= mem[adr_i[7:2]];
			end else wait_r <= wait_r + 2'h1;
		end else begin
			// Released bus inverts the last word every cycle instead of holding it
			dat_o <= ~dat_o;
		end
	end
endmodule // mdc_fab
`default_nettype wire

// file: mdc_dma_test.sv
// Register-driven testbench for the DMA controller
`timescale 1ns/10ps
`default_nettype none
`include "mdc_defs.vh"
module mdc_dma_test;
	logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, m_cyc, m_stb, m_we, m_ack, prq, irq_o;
	logic slow;
	logic [7:0] wb_adr;
	logic [31:0] wb_dat, wb_dat_o, m_adr, m_dato, m_dati, v;
	logic [3:0] m_sel;
	int err_total = 0;
	int cmp_count = 0;
	int si [0:2] = '{1, 0, -1};
	mdc_dma #(.CW(16)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .m_cyc_o(m_cyc), .m_stb_o(m_stb),
		.m_we_o(m_we), .m_adr_o(m_adr), .m_sel_o(m_sel), .m_dat_o(m_dato), .m_dat_i(m_dati),
		.m_ack_i(m_ack), .prq_i(prq), .irq_o(irq_o));
	mdc_fab fab (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .cyc_i(m_cyc), .stb_i(m_stb),
		.we_i(m_we), .adr_i(m_adr), .dat_i(m_dato), .dat_o(m_dati), .ack_o(m_ack));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic stop_test;
		$display("compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] d);
		int n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
		if (n >= 50) err_total++;
		v = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		wb_io(1'b1, adr, d);
	endtask
	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		wb_io(1'b0, adr, 32'h0);
		chk(v, exp);
	endtask
	task automatic wait_idle;
		int n = 0;
		// Poll status until the busy bit drops
		do wb_io(1'b0, `MDC_OFF_STAT, 32'h0); while (v[0] !== 1'b0 && ++n < 200);
		if (n >= 200) err_total++;
	endtask
	initial begin
		#300000;
		err_total++;
		stop_test;
	end
	initial begin
		rst_i = 1'b1;
		{wb_cyc, wb_stb, wb_we, slow} = 4'h0;
		wb_adr = 8'h00;
		wb_dat = 32'h0;
		prq = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`MDC_OFF_CFG, 32'h0);
		rd(`MDC_OFF_XCNT, 32'h1);
		rd(`MDC_OFF_CRC, 32'hFFFFFFFF);
		rd(8'h44, 32'h0);
		for (int i = 0; i < 3; i++) begin
			slow <= i[0];
			wr(`MDC_OFF_SRC, 32'h8);
			wr(`MDC_OFF_SSTR, si[i] * 4);
			wr(`MDC_OFF_XCNT, 32'h3);
			wr(`MDC_OFF_DST, 32'h80 + i * 16);
			wr(`MDC_OFF_DSTR, 32'h4);
			wr(`MDC_OFF_IMASK, 32'h1);
			wr(`MDC_OFF_CFG, 32'h1);
			wait_idle;
			for (int k = 0; k < 3; k++) chk(fab.mem[32 + i * 4 + k], 32'hA0000002 + k * si[i]);
			chk(irq_o, 1'b1);
			rd(`MDC_OFF_ISTAT, 32'h1);
			rd(`MDC_OFF_CFG, 32'h0);
			rd(`MDC_OFF_SRC, 32'h8);
			wr(`MDC_OFF_ISTAT, 32'h1);
			chk(irq_o, 1'b0);
		end
		prq <= 1'b0;
		wr(`MDC_OFF_SRC, 32'h0);
		wr(`MDC_OFF_XCNT, 32'h1);
		wr(`MDC_OFF_DST, 32'hF0);
		wr(`MDC_OFF_CFG, 32'h11);
		repeat (20) @(posedge clk_i);
		chk(m_cyc, 1'b0);
		prq <= 1'b1;
		wait_idle;
		chk(fab.mem[60], 32'hA0000000);
		fab.mem[48] = 32'h0;
		fab.mem[49] = 32'h10;
		fab.mem[50] = 32'h2;
		fab.mem[51] = 32'h0;
		wr(`MDC_OFF_ISTAT, 32'hF);
		wr(`MDC_OFF_SSTR, 32'h4);
		wr(`MDC_OFF_DPTR, 32'hC0);
		wr(`MDC_OFF_DST, 32'hD0);
		wr(`MDC_OFF_CFG, 32'h7);
		wait_idle;
		chk(fab.mem[52], 32'hA0000004);
		chk(fab.mem[53], 32'hA0000005);
		wb_io(1'b0, `MDC_OFF_ISTAT, 32'h0);
		chk(v & 32'h1, 32'h1);
		wr(`MDC_OFF_ISTAT, 32'hF);
		// Scrub one word with CRC compare against a zero sum
		wr(`MDC_OFF_XCNT, 32'h1);
		wr(`MDC_OFF_CFG, 32'hE1);
		wait_idle;
		rd(`MDC_OFF_ISTAT, 32'h9);
		wr(`MDC_OFF_ISTAT, 32'hF);
		wr(`MDC_OFF_IMASK, 32'h0);
		wr(`MDC_OFF_SRC, 32'h0);
		wr(`MDC_OFF_XCNT, 32'h4);
		wr(`MDC_OFF_DST, 32'hE0);
		wr(`MDC_OFF_CFG, 32'h103);
		repeat (100) @(posedge clk_i);
		wb_io(1'b0, `MDC_OFF_ISTAT, 32'h0);
		chk(v & 32'h6, 32'h6);
		chk(irq_o, 1'b0);
		wr(`MDC_OFF_CFG, 32'h0);
		wait_idle;
		stop_test;
	end
endmodule // mdc_dma_test
`default_nettype wire
